//--- rtl/stcu_consts.svh
// Constants of the sixteen-bit counter unit
`ifndef STCU_CONSTS_SVH
`define STCU_CONSTS_SVH
`define STCU_CNT_W 16
`define STCU_BYTE_W 8
`define STCU_ADDR_W 3
`define STCU_ADDR_CNT_LO 3'h0
`define STCU_ADDR_CNT_HI 3'h1
`define STCU_ADDR_CTRL_A 3'h2
`define STCU_ADDR_CTRL_B 3'h3
`define STCU_ADDR_CMP_LO 3'h4
`define STCU_ADDR_CMP_HI 3'h5
`define STCU_ADDR_FLAGS 3'h6
`define STCU_COUNT_FLOOR_IND 16'h0000
`define STCU_MAX 16'hFFFF
`define STCU_TOP_8 16'h00FF
`define STCU_TOP_9 16'h01FF
`define STCU_TOP_10 16'h03FF
`define STCU_CS_LSB 0
`define STCU_CS_MSB 2
`define STCU_WGM_LO_LSB 0
`define STCU_WGM_LO_MSB 1
`define STCU_WGM_HI_LSB 3
`define STCU_WGM_HI_MSB 4
`define STCU_PRESC_W 10
`define STCU_TAP_8 3
`define STCU_TAP_64 6
`define STCU_TAP_256 8
`endif

//--- rtl/stcu_counter.sv
// Sixteen-bit timer counter with byte access through a shared high-byte holding register
//
// Contract
// - Sixteen-bit counter counting up or down
// - Counter seen as high and low bytes
// - High byte access hits holding register
// - Low byte read copies high to holder
// - Low byte write loads high from holder
// - Full value moves in one cycle
// - Each tick clears, increments or decrements
// - Three-bit clock select picks tick source
// - Select zero stops the counter
// - Counter accessible with or without tick
// - Processor write beats clear or count
// - Four-bit mode split across controls A, B
// - Overflow flag set per mode
// - Holding register survives low byte writes
// - Clear forces every counter bit zero
// - Count_floor_ind and top indications generated
// - One holder shared by all wide registers
// - Zero is the count_floor_ind of range
// - Top from fixed value or compare
`timescale 1ns/1ps
`default_nettype none
`include "stcu_consts.svh"
module stcu_counter #(
	parameter int CNT_W = `STCU_CNT_W,
	parameter int PRESC_W = `STCU_PRESC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire stcu_pkg::stcu_bus_type bus,
	input wire logic ext_clk_pin,
	output logic [7:0] rdata,
	output logic counter_overflow_flag,
	output logic overflow_irq,
	output logic count_floor_ind,
	output logic count_top_ind
);
	typedef struct packed {
		logic [CNT_W-1:0] count_value;
		logic [7:0] hold;
		logic [7:0] control_reg_a;
		logic [7:0] control_reg_b;
		logic [CNT_W-1:0] compare_value;
		logic ovf;
		logic ovf_ie;
		logic down;
		logic [7:0] rdata;
	} stcu_state_type;
	stcu_state_type st_reg, st_next;
	logic tick;
	logic [3:0] waveform_gen_mode;
	logic [CNT_W-1:0] top;
	logic at_top, at_count_floor_ind, wr_lo, rd_lo, phase_correct;
	stcu_pkg::stcu_act_type act;

	stcu_tick_gen #(
		.PRESC_W(PRESC_W)
	) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.sel(st_reg.control_reg_b[`STCU_CS_MSB:`STCU_CS_LSB]),
		.ext_pin(ext_clk_pin),
		.tick(tick)
	);

	// Mode field split: low two bits in control A, high two in control B
	assign waveform_gen_mode = {st_reg.control_reg_b[`STCU_WGM_HI_MSB:`STCU_WGM_HI_LSB],
		st_reg.control_reg_a[`STCU_WGM_LO_MSB:`STCU_WGM_LO_LSB]};

	always_comb begin
		case (waveform_gen_mode)
			4'h1, 4'h5: top = `STCU_TOP_8;
			4'h2, 4'h6: top = `STCU_TOP_9;
			4'h3, 4'h7: top = `STCU_TOP_10;
			4'h4, 4'h9, 4'hB, 4'hF: top = st_reg.compare_value;
			4'h8, 4'hA, 4'hC, 4'hE: top = st_reg.compare_value;
			default: top = `STCU_MAX;
		endcase
	end
	// Modes 1-3, 8-11 run up and down; the rest saw upward
	assign phase_correct = (waveform_gen_mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
	assign at_top = (st_reg.count_value == top);
	assign at_count_floor_ind = (st_reg.count_value == `STCU_COUNT_FLOOR_IND);
	assign wr_lo = bus.wr && bus.addr == `STCU_ADDR_CNT_LO;
	assign rd_lo = bus.rd && bus.addr == `STCU_ADDR_CNT_LO;

	always_comb begin
		if (!tick) begin
			act = stcu_pkg::STCU_ACT_HOLD;
		end else if (phase_correct) begin
			act = (st_reg.down || at_top) ? stcu_pkg::STCU_ACT_DOWN : stcu_pkg::STCU_ACT_UP;
			if (st_reg.down && at_count_floor_ind) begin
				act = stcu_pkg::STCU_ACT_UP;
			end
		end else if (at_top && waveform_gen_mode != 4'h0) begin
			act = stcu_pkg::STCU_ACT_CLEAR;
		end else begin
			act = stcu_pkg::STCU_ACT_UP;
		end
	end

	always_comb begin
		st_next = st_reg;
		// Next-state counter action; a processor write below overrides it
		case (act)
			stcu_pkg::STCU_ACT_UP: st_next.count_value = st_reg.count_value + 1'b1;
			stcu_pkg::STCU_ACT_DOWN: st_next.count_value = st_reg.count_value - 1'b1;
			stcu_pkg::STCU_ACT_CLEAR: st_next.count_value = '0;
			default: st_next.count_value = st_reg.count_value;
		endcase
		if (tick && phase_correct) begin
			if (at_top) begin
				st_next.down = 1'b1;
			end else if (at_count_floor_ind) begin
				st_next.down = 1'b0;
			end
		end else if (!phase_correct) begin
			st_next.down = 1'b0;
		end
		// Overflow: at top in normal/fast modes, at count_floor_ind in dual-slope
		if (tick && ((phase_correct && at_count_floor_ind && st_reg.down) ||
			(!phase_correct && at_top))) begin
			st_next.ovf = 1'b1;
		end
		st_next.rdata = st_reg.rdata;
		if (bus.rd) begin
			case (bus.addr)
				`STCU_ADDR_CNT_LO: begin
					st_next.rdata = st_reg.count_value[7:0];
					st_next.hold = st_reg.count_value[15:8];
				end
				`STCU_ADDR_CNT_HI: st_next.rdata = st_reg.hold;
				`STCU_ADDR_CTRL_A: st_next.rdata = st_reg.control_reg_a;
				`STCU_ADDR_CTRL_B: st_next.rdata = st_reg.control_reg_b;
				`STCU_ADDR_CMP_LO: st_next.rdata = st_reg.compare_value[7:0];
				`STCU_ADDR_CMP_HI: st_next.rdata = st_reg.compare_value[15:8];
				`STCU_ADDR_FLAGS: st_next.rdata = {6'h00, st_reg.ovf_ie, st_reg.ovf};
				default: st_next.rdata = 8'h00;
			endcase
		end
		if (bus.wr) begin
			case (bus.addr)
				`STCU_ADDR_CNT_LO: begin
					st_next.count_value = {st_reg.hold, bus.wdata};
					st_next.down = st_reg.down;
				end
				`STCU_ADDR_CNT_HI, `STCU_ADDR_CMP_HI: st_next.hold = bus.wdata;
				`STCU_ADDR_CMP_LO: st_next.compare_value = {st_reg.hold, bus.wdata};
				`STCU_ADDR_CTRL_A: st_next.control_reg_a = bus.wdata;
				`STCU_ADDR_CTRL_B: st_next.control_reg_b = bus.wdata;
				`STCU_ADDR_FLAGS: begin
					st_next.ovf_ie = bus.wdata[1];
					// Write one to clear; a fresh overflow in the same cycle wins only while the flag is still clear
					if (bus.wdata[0] && !(st_next.ovf && !st_reg.ovf)) begin
						st_next.ovf = 1'b0;
					end
				end
				default: st_next.hold = st_reg.hold;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	assign counter_overflow_flag = st_reg.ovf;
	assign overflow_irq = st_reg.ovf && st_reg.ovf_ie;
	assign count_floor_ind = at_count_floor_ind;
	assign count_top_ind = at_top;

	chk_write_wins_count: assert property (@(posedge clk) disable iff (!rst_n)
		wr_lo |=> st_reg.count_value == {$past(st_reg.hold), $past(bus.wdata)})
		else $error("low write did not load full value");
	chk_read_copies_high: assert property (@(posedge clk) disable iff (!rst_n)
		rd_lo && !bus.wr |=> st_reg.hold == $past(st_reg.count_value[15:8]))
		else $error("low read did not latch high byte");
	chk_stop_holds_count: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.control_reg_b[2:0] == 3'h0 && !bus.wr ##1 st_reg.control_reg_b[2:0] == 3'h0
		|-> $stable(st_reg.count_value))
		else $error("counter moved while stopped");
	chk_tick_moves_count: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !bus.wr && !at_top && !phase_correct |=> st_reg.count_value == $past(st_reg.count_value) + 16'h0001)
		else $error("tick did not increment");
	chk_top_clears: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !bus.wr && at_top && !phase_correct && waveform_gen_mode != 4'h0 |=> st_reg.count_value == 16'h0000)
		else $error("clear at top missing");
	chk_ovf_sets: assert property (@(posedge clk) disable iff (!rst_n)
		tick && at_top && !phase_correct |=> st_reg.ovf)
		else $error("overflow flag not set");
	chk_holder_kept: assert property (@(posedge clk) disable iff (!rst_n)
		wr_lo && !bus.rd |=> $stable(st_reg.hold))
		else $error("holder changed on low write");
	chk_high_read_holder: assert property (@(posedge clk) disable iff (!rst_n)
		bus.rd && bus.addr == 3'h1 |=> rdata == $past(st_reg.hold))
		else $error("high read not from holder");
	chk_floor_ind: assert property (@(posedge clk) disable iff (!rst_n)
		count_floor_ind == (st_reg.count_value == 16'h0000))
		else $error("floor indication wrong");
	// Dual-slope turning points: the direction flag is the only memory of the slope
	chk_floor_turns: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !wr_lo && phase_correct && at_count_floor_ind && st_reg.down |=> st_reg.count_value == 16'h0001 && !st_reg.down)
		else $error("dual-slope count did not turn at count_floor_ind");
	chk_top_turns: assert property (@(posedge clk) disable iff (!rst_n)
		tick && !wr_lo && phase_correct && at_top |=> st_reg.down)
		else $error("dual-slope count did not turn at top");
	chk_dual_ovf: assert property (@(posedge clk) disable iff (!rst_n)
		tick && phase_correct && at_count_floor_ind && st_reg.down |=> st_reg.ovf)
		else $error("overflow flag not set at count_floor_ind");
	chk_ovf_needs_tick: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_reg.ovf) |-> $past(tick))
		else $error("overflow flag rose without a tick");
	chk_flag_clears: assert property (@(posedge clk) disable iff (!rst_n)
		bus.wr && bus.addr == `STCU_ADDR_FLAGS && bus.wdata[0] && !tick |=> !st_reg.ovf)
		else $error("overflow flag not cleared");
	chk_saw_no_down: assert property (@(posedge clk) disable iff (!rst_n)
		!phase_correct && !wr_lo |=> !st_reg.down)
		else $error("single-slope mode left counting down");
endmodule
`default_nettype wire

//--- rtl/stcu_pkg.sv
// Types of the sixteen-bit counter unit
`default_nettype none
package stcu_pkg;
	typedef enum logic [1:0] {
		STCU_ACT_HOLD = 2'h0,
		STCU_ACT_UP = 2'h1,
		STCU_ACT_DOWN = 2'h2,
		STCU_ACT_CLEAR = 2'h3
	} stcu_act_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} stcu_bus_type;
	typedef struct packed {
		logic [2:0] sel;
		logic ext_rise;
	} stcu_tick_in_type;
endpackage
`default_nettype wire

//--- rtl/stcu_tick_gen.sv
// Timer tick source: prescaler taps and filtered external pin
`timescale 1ns/1ps
`default_nettype none
`include "stcu_consts.svh"
module stcu_tick_gen #(
	parameter int PRESC_W = `STCU_PRESC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] sel,
	input wire logic ext_pin,
	output logic tick
);
	// Taps shrink with a short prescaler, so small simulation builds still elaborate
	localparam int TAP8 = (`STCU_TAP_8 < PRESC_W) ? `STCU_TAP_8 : PRESC_W;
	localparam int TAP64 = (`STCU_TAP_64 < PRESC_W) ? `STCU_TAP_64 : PRESC_W;
	localparam int TAP256 = (`STCU_TAP_256 < PRESC_W) ? `STCU_TAP_256 : PRESC_W;
	typedef struct packed {
		logic [PRESC_W-1:0] presc;
		logic [2:0] sync;
		logic ext_lvl;
	} stcu_tick_state_type;
	stcu_tick_state_type st_reg, st_next;
	logic rise, fall;
	always_comb begin
		st_next = st_reg;
		st_next.presc = st_reg.presc + 1'b1;
		st_next.sync = {st_reg.sync[1:0], ext_pin};
		rise = 1'b0;
		fall = 1'b0;
		// Level changes only when the second and third stages agree
		if (st_reg.sync[1] == st_reg.sync[2] && st_reg.sync[2] != st_reg.ext_lvl) begin
			st_next.ext_lvl = st_reg.sync[2];
			rise = st_reg.sync[2];
			fall = !st_reg.sync[2];
		end
		case (sel)
			3'h0: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = &st_reg.presc[TAP8-1:0];
			3'h3: tick = &st_reg.presc[TAP64-1:0];
			3'h4: tick = &st_reg.presc[TAP256-1:0];
			3'h5: tick = &st_reg.presc[PRESC_W-1:0];
			3'h6: tick = fall;
			3'h7: tick = rise;
			default: tick = 1'b0;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	chk_stopped_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
		sel == 3'h0 |-> !tick) else $error("tick while stopped");
endmodule
`default_nettype wire

//--- verif/stcu_counter_test.sv
// Self-checking bench for the sixteen-bit counter unit
`timescale 1ns/1ps
`default_nettype none
`include "stcu_consts.svh"
module stcu_counter_test;
	logic clk;
	logic rst_n;
	logic ext_clk_pin;
	stcu_pkg::stcu_bus_type bus;
	logic [7:0] rdata;
	logic ovf, irq, floor_ind, top_ind;
	int n_errors;
	int comparisons;
	// Short prescaler keeps the slowest divider tap inside the run
	stcu_counter #(.PRESC_W(4)) i_stcu_counter (.clk(clk), .rst_n(rst_n), .bus(bus), .ext_clk_pin(ext_clk_pin),
		.rdata(rdata), .counter_overflow_flag(ovf), .overflow_irq(irq), .count_floor_ind(floor_ind),
		.count_top_ind(top_ind));
	stcu_cpu_model i_stcu_cpu_model (.clk(clk), .rdata(rdata), .bus(bus));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic scen_access;
		logic [15:0] v;
		check({14'h0, floor_ind, ovf}, 16'h0002);
		i_stcu_cpu_model.wr16(`STCU_ADDR_CNT_LO, 16'h01FF);
		repeat (20) @(posedge clk);
		i_stcu_cpu_model.wr(`STCU_ADDR_CNT_HI, 8'h77);
		i_stcu_cpu_model.rd(`STCU_ADDR_CNT_HI, v[7:0]);
		check({8'h00, v[7:0]}, 16'h0077);
		i_stcu_cpu_model.rd16(`STCU_ADDR_CNT_LO, v);
		check(v, 16'h01FF);
		i_stcu_cpu_model.wr(`STCU_ADDR_CMP_HI, 8'hC3);
		i_stcu_cpu_model.wr(`STCU_ADDR_CNT_LO, 8'h12);
		i_stcu_cpu_model.wr(`STCU_ADDR_CNT_LO, 8'h34);
		i_stcu_cpu_model.rd16(`STCU_ADDR_CNT_LO, v);
		check(v, 16'hC334);
	endtask
	task automatic scen_top;
		i_stcu_cpu_model.wr16(`STCU_ADDR_CNT_LO, `STCU_TOP_8);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_A, 8'h01);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h08);
		@(negedge clk);
		check({14'h0, floor_ind, top_ind}, 16'h0001);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_A, 8'h00);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h00);
		@(negedge clk);
		check({15'h0, top_ind}, 16'h0000);
	endtask
	task automatic scen_sources;
		logic [15:0] v;
		for (int s = 1; s < 8; s++) begin
			i_stcu_cpu_model.wr16(`STCU_ADDR_CNT_LO, `STCU_COUNT_FLOOR_IND);
			i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, {5'h00, s[2:0]});
			repeat (600) @(posedge clk);
			i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h00);
			i_stcu_cpu_model.rd16(`STCU_ADDR_CNT_LO, v);
			check({15'h0, v == 16'h0000}, 16'h0000);
		end
	endtask
	task automatic scen_overflow;
		logic [7:0] b;
		int i;
		i_stcu_cpu_model.wr16(`STCU_ADDR_CNT_LO, 16'hFFFE);
		i_stcu_cpu_model.wr(`STCU_ADDR_FLAGS, 8'h01);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h01);
		i = 0;
		while (ovf !== 1'b1 && i < 40) begin
			@(negedge clk);
			i++;
		end
		if (i == 40) begin
			n_errors++;
			end_sim();
		end
		// Overwrite while ticking; the write must win over the count
		i_stcu_cpu_model.wr16(`STCU_ADDR_CNT_LO, 16'h0100);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h00);
		i_stcu_cpu_model.rd(`STCU_ADDR_CNT_LO, b);
		i_stcu_cpu_model.rd(`STCU_ADDR_CNT_HI, b);
		check({8'h00, b}, 16'h0001);
		i_stcu_cpu_model.wr(`STCU_ADDR_FLAGS, 8'h02);
		@(negedge clk);
		check({14'h0, ovf, irq}, 16'h0003);
		i_stcu_cpu_model.wr(`STCU_ADDR_FLAGS, 8'h01);
		@(negedge clk);
		check({14'h0, ovf, irq}, 16'h0000);
	endtask
	task automatic scen_dual;
		logic [15:0] v;
		int i;
		i_stcu_cpu_model.wr16(`STCU_ADDR_CNT_LO, 16'h00FE);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_A, 8'h01);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h01);
		i = 0;
		// Up to the 8-bit top and back down to zero takes about 256 ticks
		while (ovf !== 1'b1 && i < 300) begin
			@(negedge clk);
			i++;
		end
		if (i == 300) begin
			n_errors++;
			end_sim();
		end
		check({15'h0, i > 250 && i < 266}, 16'h0001);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_B, 8'h00);
		i_stcu_cpu_model.rd16(`STCU_ADDR_CNT_LO, v);
		check({15'h0, v < 16'h0010}, 16'h0001);
		i_stcu_cpu_model.wr(`STCU_ADDR_CTRL_A, 8'h00);
		i_stcu_cpu_model.wr(`STCU_ADDR_FLAGS, 8'h01);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		ext_clk_pin = 1'b0;
		forever begin
			repeat (8) @(posedge clk);
			ext_clk_pin <= ~ext_clk_pin;
		end
	end
	initial begin
		rst_n = 1'b0;
		n_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		scen_access();
		scen_top();
		scen_sources();
		scen_overflow();
		scen_dual();
		end_sim();
	end
endmodule
`default_nettype wire

//--- verif/stcu_cpu_model.sv
// Processor core model issuing byte accesses to the counter unit
`timescale 1ns/1ps
`default_nettype none
module stcu_cpu_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var stcu_pkg::stcu_bus_type bus
);
	initial bus = '0;
	// Whole access runs uninterrupted, so the holder is never shared mid-pair
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
		wr(lo + 3'h1, v[15:8]);
		wr(lo, v[7:0]);
	endtask
	task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
		rd(lo, v[7:0]);
		rd(lo + 3'h1, v[15:8]);
	endtask
endmodule
`default_nettype wire
